/* hw/audio_slot_defines.svh */
// Register offsets, field positions and reset values of the audio slot
// control block. Definitions only; included by bare name.
`ifndef AUDIO_SLOT_DEFINES_SVH
`define AUDIO_SLOT_DEFINES_SVH

`define ADR_W          12
`define OFF_AUDIO_CFG  12'h0f4
`define OFF_CLK_CFG    12'h0f8
`define OFF_LEVEL      12'h140
`define OFF_IRQ_STAT   12'h144
`define OFF_IRQ_MASK   12'h148
`define OFF_DMA_EN     12'h14c

`define CFG_RESET      32'h0000_0000
`define ZERO_WORD      32'h0000_0000
`define ONE_WORD       32'h0000_0001

`define MODE_LSB       29
`define MODE_W         3
`define MODE_OFF       3'h0
`define PEAK_LSB       22
`define PEAK_W         7
`define WS0_CTRL_LSB   18
`define WS0_SYNC_LSB   16
`define WS_STRIDE      4
`define CLK1_LSB       27
`define CLK2_LSB       22
`define SRC_W          5

`define SRC_OWN        5'h00
`define SRC_OTHER      5'h01
`define SRC_MCLK       5'h02

`define IRQ_LEVEL      0
`define IRQ_START1     1
`define IRQ_START2     2
`define IRQ_APPLY      3
`define IRQ_W          4
`define DMA_W          4

`endif

/* hw/audio_slot_pkg.sv */
// Types shared by the audio slot control modules.
// Assumes nothing of its surroundings.
package audio_slot_pkg;

  typedef enum logic [1:0] {
    WS_HIZ      = 2'b00,
    WS_LIST_ONE = 2'b01,
    WS_LIST_TWO = 2'b10,
    WS_LOW      = 2'b11
  } ws_func_t;

  typedef enum logic [1:0] {
    TM_STEREO      = 2'b00,
    TM_SLOT        = 2'b01,
    TM_PRE_PULSE   = 2'b10,
    TM_FRAME_PULSE = 2'b11
  } ws_timing_t;

  typedef enum logic [1:0] {
    PORT_OFF  = 2'b00,
    PORT_WAIT = 2'b01,
    PORT_RUN  = 2'b10
  } port_state_t;

endpackage

/* hw/bit_clock_if.sv */
// Carries a bit clock source code to a generator and its bit tick back.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface bit_clock_if;
  logic [4:0] source;
  logic       tick;
  modport ctl (output source, input tick);
  modport gen (input source, output tick);
endinterface

/* hw/bit_clock_gen.sv */
// Bit tick generator for one audio port: own pin, other pin, master clock
// or master clock divided. Pins are sampled synchronously to clk_i and
// must be well below half the system clock rate.
`timescale 1ns/1ps
module bit_clock_gen #(
  parameter bit PORT_TWO = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bit_clock_pin_one_i,
  input  wire logic bit_clock_pin_two_i,
  input  wire logic audio_master_clock_i,
  bit_clock_if.gen  bc
);
  import audio_slot_pkg::*;
  `include "audio_slot_defines.svh"

  // Division ratio per source code; zero marks a non-divided or reserved code
  function automatic logic [8:0] div_of(input logic [4:0] code);
    case (code)
      5'h03:   div_of = 9'h002;
      5'h04:   div_of = 9'h003;
      5'h05:   div_of = 9'h004;
      5'h06:   div_of = 9'h006;
      5'h07:   div_of = 9'h008;
      5'h08:   div_of = 9'h00c;
      5'h09:   div_of = 9'h010;
      5'h0a:   div_of = 9'h018;
      5'h0b:   div_of = 9'h020;
      5'h0c:   div_of = 9'h030;
      5'h0d:   div_of = 9'h040;
      5'h0e:   div_of = 9'h060;
      5'h0f:   div_of = 9'h080;
      5'h10:   div_of = 9'h0c0;
      5'h11:   div_of = 9'h100;
      5'h12:   div_of = 9'h180;
      default: div_of = 9'h000;
    endcase
  endfunction

  logic       p1_q, p2_q, mc_q, tick_r;
  logic [8:0] cnt_r;
  logic [4:0] src_q;

  wire       p1_rise   = bit_clock_pin_one_i & ~p1_q;
  wire       p2_rise   = bit_clock_pin_two_i & ~p2_q;
  wire       mc_rise   = audio_master_clock_i & ~mc_q;
  wire       own_rise  = PORT_TWO ? p2_rise : p1_rise;
  wire       oth_rise  = PORT_TWO ? p1_rise : p2_rise;
  wire [8:0] div       = div_of(bc.source);
  wire       div_wrap  = mc_rise & (div != 9'h000) &
                         (cnt_r == div - 9'h001);
  // Reserved codes 13..1F leave the port without a bit clock
  wire       tick_nxt  = (bc.source == `SRC_OWN)   ? own_rise :
                         (bc.source == `SRC_OTHER) ? oth_rise :
                         (bc.source == `SRC_MCLK)  ? mc_rise  :
                         div_wrap;  // see [R10] see [R11]
  // A new source restarts the divider so the first period is whole
  wire [8:0] cnt_nxt   = (src_q != bc.source || div_wrap) ? 9'h000 :
                         mc_rise ? cnt_r + 9'h001 : cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_q   <= 1'b0;
      p2_q   <= 1'b0;
      mc_q   <= 1'b0;
      cnt_r  <= 9'h000;
      src_q  <= `SRC_OWN;
      tick_r <= 1'b0;
    end else begin
      p1_q   <= bit_clock_pin_one_i;
      p2_q   <= bit_clock_pin_two_i;
      mc_q   <= audio_master_clock_i;
      cnt_r  <= cnt_nxt;
      src_q  <= bc.source;
      tick_r <= tick_nxt;
    end
  end

  assign bc.tick = tick_r;
endmodule

/* hw/audio_slot_serial_control.sv */
// Control of two slot-list driven serial audio ports: level monitoring,
// word-select line timing, bit clock selection and buffered mode switch.
// Assumes a classic Wishbone master and an external slot-list engine
// that supplies slot marks, pointer resets and captured sample bytes.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Operation
// [R1] Compare magnitude of each sample's top byte with the peak limit.
// [R2] Peak limit is a seven-bit field, so values 0 to 127 only.
// [R3] One violation flag per slot record, 32 flags in one register.
// [R4] Comparison never stops; reading the flags returns and clears them.
// [R5] Function code picks hi-Z input, list one, list two or low output.
// [R6] Code 00: line changes one bit before slot start, whole slot long.
// [R7] Code 01: line follows the slot exactly from its first bit.
// [R8] Code 10: one-bit pulse just before slot start.
// [R9] Code 11: pulse at first bit, two bits long in superframe start.
// [R10] Source 00 own pin, 01 other port's pin, 02 master clock.
// [R11] Sources 03 to 12 divide the master clock; 13 and up reserved.
// [R12] Mode and line settings apply at protection address or when idle.
// [R13] An enabled port starts only at its next slot pointer reset.
// [R14] Disabling a DMA channel flushes its FIFO and rewinds pointers.
// [R15] Software enables output DMA before turning a port on.
// [R16] Software keeps slot lists, buffers and protection address consistent.
// [R17] Three-bit mode picks active lists; zero turns both ports off.
// [R18] Flags 0 to 15 belong to list one, 16 to 31 to list two.
module audio_slot_serial_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        bit_clock_pin_one_i,
  input  wire logic        bit_clock_pin_two_i,
  input  wire logic        audio_master_clock_i,
  input  wire logic [4:0]  word_select_i,
  output logic      [4:0]  word_select_o,
  output logic      [4:0]  word_select_oe_o,
  input  wire logic [1:0]  slot_next_msb_i,
  input  wire logic [1:0]  superframe_next_i,
  input  wire logic [4:0]  ws_mark_one_i,
  input  wire logic [4:0]  ws_mark_two_i,
  input  wire logic [1:0]  slot_pointer_reset_i,
  input  wire logic        protection_reached_i,
  input  wire logic        sample_valid_i,
  input  wire logic [4:0]  sample_record_i,
  input  wire logic [7:0]  sample_msb_byte_i,
  output logic      [1:0]  list_pointer_reset_o,
  output logic      [1:0]  port_active_o,
  output logic      [1:0]  bit_tick_o,
  output logic      [3:0]  dma_flush_o
);
  import audio_slot_pkg::*;
  `include "audio_slot_defines.svh"

  // Byte-lane merge of a Wishbone write into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  lanes);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = lanes[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  // Which ports a mode turns on; port 0 is port one
  function automatic logic port_on(input logic [2:0] mode,
                                   input int         port);
    if (port == 0) begin
      port_on = (mode != 3'h0) && (mode != 3'h2);
    end else begin
      port_on = (mode != 3'h0) && (mode != 3'h1);
    end
  endfunction

  logic [31:0]          cfg_sh_r, cfg_wk_r, clk_cfg_r, level_r, dat_r;
  logic [`IRQ_W-1:0]    stat_r, mask_r;
  logic [`DMA_W-1:0]    dma_en_r, flush_r;
  logic                 ack_r, irq_r;
  logic [1:0]           lrst_r, act_r, msb_r, sf_cur_r;
  logic [4:0]           mark_cur_r [2];
  logic [4:0]           ws_in_q, ws_r, hold_r, wso_r, wsoe_r;
  port_state_t          st_r [2];
  port_state_t          st_nxt [2];
  logic [1:0]           start_ev;

  // Wishbone slave: every access, mapped or not, is answered one cycle on
  wire req     = cyc_i & stb_i & ~ack_r;
  wire wr      = req & we_i;
  wire rd      = req & ~we_i;
  wire hit_cfg = (adr_i == `OFF_AUDIO_CFG);
  wire hit_clk = (adr_i == `OFF_CLK_CFG);
  wire hit_lvl = (adr_i == `OFF_LEVEL);
  wire hit_st  = (adr_i == `OFF_IRQ_STAT);
  wire hit_msk = (adr_i == `OFF_IRQ_MASK);
  wire hit_dma = (adr_i == `OFF_DMA_EN);

  wire [31:0] rdata =
    hit_cfg ? cfg_sh_r :
    hit_clk ? clk_cfg_r :
    hit_lvl ? level_r :
    hit_st  ? {{(32-`IRQ_W){1'b0}}, stat_r} :
    hit_msk ? {{(32-`IRQ_W){1'b0}}, mask_r} :
    hit_dma ? {{(32-`DMA_W){1'b0}}, dma_en_r} : `ZERO_WORD;

  wire [31:0] cfg_sh_nxt = (wr & hit_cfg) ?
                           merge(cfg_sh_r, dat_i, sel_i) : cfg_sh_r;
  wire [31:0] clk_nxt    = (wr & hit_clk) ?
                           merge(clk_cfg_r, dat_i, sel_i) : clk_cfg_r;
  wire [31:0] msk_word   = merge({{(32-`IRQ_W){1'b0}}, mask_r}, dat_i, sel_i);
  wire [31:0] dma_word   = merge({{(32-`DMA_W){1'b0}}, dma_en_r}, dat_i,
                                 sel_i);
  wire [`IRQ_W-1:0] mask_nxt = (wr & hit_msk) ? msk_word[`IRQ_W-1:0] : mask_r;
  wire [`DMA_W-1:0] dma_nxt  = (wr & hit_dma) ? dma_word[`DMA_W-1:0]
                                              : dma_en_r;
  // A falling enable bit gives the channel a one-cycle flush strobe
  wire [`DMA_W-1:0] flush_nxt = dma_en_r & ~dma_nxt;  // see [R14]

  // Level monitor; the seven-bit field cannot hold 128
  wire [`PEAK_W-1:0] peak = cfg_sh_r[`PEAK_LSB +: `PEAK_W];  // see [R2]
  wire [7:0]  mag      = sample_msb_byte_i[7] ?
                         (~sample_msb_byte_i + 8'h01) : sample_msb_byte_i;
  wire        exceed   = sample_valid_i & (mag > {1'b0, peak});  // see [R1]
  // Record index 0..15 is list one, 16..31 list two
  wire [31:0] lvl_set  = exceed ? (`ONE_WORD << sample_record_i)
                                : `ZERO_WORD;  // see [R18]
  // A violation in the reading cycle survives the clear
  wire [31:0] level_nxt = ((rd & hit_lvl) ? `ZERO_WORD : level_r) |
                          lvl_set;  // see [R3] see [R4]

  // Shadowed settings reach the working copy at the protection address
  // or at once while both ports are off
  wire [2:0] mode_wk = cfg_wk_r[`MODE_LSB +: `MODE_W];
  wire       apply   = protection_reached_i |
                       (mode_wk == `MODE_OFF);  // see [R12]
  wire       applied = apply & (cfg_wk_r != cfg_sh_r);
  wire [31:0] cfg_wk_nxt = apply ? cfg_sh_r : cfg_wk_r;

  wire [`IRQ_W-1:0] ev = {applied, start_ev[1], start_ev[0], |lvl_set};
  wire [`IRQ_W-1:0] stat_nxt = ((rd & hit_st) ? {`IRQ_W{1'b0}} : stat_r) |
                               ev;
  wire              irq_nxt  = |(stat_nxt & mask_nxt);

  // Bit clock generators, one per port
  bit_clock_if bc_one ();
  bit_clock_if bc_two ();
  assign bc_one.source = clk_cfg_r[`CLK1_LSB +: `SRC_W];
  assign bc_two.source = clk_cfg_r[`CLK2_LSB +: `SRC_W];

  bit_clock_gen #(.PORT_TWO(1'b0)) u_bclk_one (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .bit_clock_pin_one_i  (bit_clock_pin_one_i),
    .bit_clock_pin_two_i  (bit_clock_pin_two_i),
    .audio_master_clock_i (audio_master_clock_i),
    .bc                   (bc_one.gen)
  );

  bit_clock_gen #(.PORT_TWO(1'b1)) u_bclk_two (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .bit_clock_pin_one_i  (bit_clock_pin_one_i),
    .bit_clock_pin_two_i  (bit_clock_pin_two_i),
    .audio_master_clock_i (audio_master_clock_i),
    .bc                   (bc_two.gen)
  );

  wire [1:0] tick = {bc_two.tick, bc_one.tick};
  assign bit_tick_o = tick;

  // Pointer resets: slot engine or a rising edge on input-mode line 0 (list one) or line 4 (list two)
  wire [1:0] ws_func0 = cfg_wk_r[`WS0_CTRL_LSB +: 2];
  wire [1:0] ws_func4 = cfg_wk_r[`WS0_CTRL_LSB - 4*`WS_STRIDE +: 2];
  wire rise0 = word_select_i[0] & ~ws_in_q[0] & (ws_func0 == WS_HIZ);
  wire rise4 = word_select_i[4] & ~ws_in_q[4] & (ws_func4 == WS_HIZ);
  wire [1:0] lrst = slot_pointer_reset_i | {rise4, rise0};  // see [R5]
  // Locked modes run port two from the list-one pointer
  wire [1:0] port_rst = {mode_wk[2] ? lrst[0] : lrst[1], lrst[0]};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      wire en = port_on(mode_wk, p);  // see [R17]
      always_comb begin
        st_nxt[p]   = st_r[p];
        start_ev[p] = 1'b0;
        case (st_r[p])
          PORT_OFF: begin
            if (en) begin
              st_nxt[p] = PORT_WAIT;
            end
          end
          PORT_WAIT: begin
            if (!en) begin
              st_nxt[p] = PORT_OFF;
            end else if (port_rst[p]) begin
              st_nxt[p]   = PORT_RUN;  // see [R13]
              start_ev[p] = 1'b1;
            end
          end
          PORT_RUN: begin
            if (!en) begin
              st_nxt[p] = PORT_OFF;
            end
          end
          default: st_nxt[p] = PORT_OFF;
        endcase
      end

      wire run_l = (st_r[p] == PORT_RUN);
      wire [4:0] mark_nxt = (p == 0) ? ws_mark_one_i : ws_mark_two_i;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          st_r[p]       <= PORT_OFF;
          act_r[p]      <= 1'b0;
          msb_r[p]      <= 1'b0;
          sf_cur_r[p]   <= 1'b0;
          mark_cur_r[p] <= 5'h00;
        end else begin
          st_r[p]  <= st_nxt[p];
          act_r[p] <= (st_nxt[p] == PORT_RUN);
          if (tick[p] && run_l) begin
            msb_r[p] <= slot_next_msb_i[p];
            if (slot_next_msb_i[p]) begin
              mark_cur_r[p] <= mark_nxt;
              sf_cur_r[p]   <= superframe_next_i[p];
            end
          end
        end
      end
    end

    for (genvar k = 0; k < 5; k++) begin : g_ws
      wire [1:0]  func = cfg_wk_r[`WS0_CTRL_LSB - k*`WS_STRIDE +: 2];
      wire [1:0]  tmg  = cfg_wk_r[`WS0_SYNC_LSB - k*`WS_STRIDE +: 2];
      wire        l    = (func == WS_LIST_TWO);
      wire        on   = (func == WS_LIST_ONE) || (func == WS_LIST_TWO);
      wire        run  = on && (st_r[l] == PORT_RUN);
      wire        pre  = slot_next_msb_i[l];
      wire        msb  = msb_r[l];
      wire        mnx  = l ? ws_mark_two_i[k] : ws_mark_one_i[k];
      wire        mcur = mark_cur_r[l][k];
      // Next level of the line on a bit tick, per timing code
      wire ws_step =
        (tmg == TM_STEREO)    ? (pre ? mnx : ws_r[k]) :       // see [R6]
        (tmg == TM_SLOT)      ? (msb ? mcur : ws_r[k]) :      // see [R7]
        (tmg == TM_PRE_PULSE) ? (pre & mnx) :                 // see [R8]
        (msb ? mcur : (hold_r[k] & ws_r[k]));                 // see [R9]
      wire hold_step = (tmg == TM_FRAME_PULSE) & msb & mcur & sf_cur_r[l];
      // Outputs: code 11 drives a constant low, code 00 releases the pin
      wire out_nxt = run & ws_r[k];                           // see [R5]
      wire oe_nxt  = (func != WS_HIZ);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ws_r[k]   <= 1'b0;
          hold_r[k] <= 1'b0;
          wso_r[k]  <= 1'b0;
          wsoe_r[k] <= 1'b0;
        end else begin
          if (!run) begin
            ws_r[k]   <= 1'b0;
            hold_r[k] <= 1'b0;
          end else if (tick[l]) begin
            ws_r[k]   <= ws_step;
            hold_r[k] <= hold_step;
          end
          wso_r[k]  <= out_nxt;
          wsoe_r[k] <= oe_nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_sh_r  <= `CFG_RESET;
      cfg_wk_r  <= `CFG_RESET;
      clk_cfg_r <= `CFG_RESET;
      level_r   <= `ZERO_WORD;
      stat_r    <= {`IRQ_W{1'b0}};
      mask_r    <= {`IRQ_W{1'b0}};
      dma_en_r  <= {`DMA_W{1'b0}};
      flush_r   <= {`DMA_W{1'b0}};
      ack_r     <= 1'b0;
      dat_r     <= `ZERO_WORD;
      irq_r     <= 1'b0;
      ws_in_q   <= 5'h00;
      lrst_r    <= 2'b00;
    end else begin
      cfg_sh_r  <= cfg_sh_nxt;
      cfg_wk_r  <= cfg_wk_nxt;
      clk_cfg_r <= clk_nxt;
      level_r   <= level_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      dma_en_r  <= dma_nxt;
      flush_r   <= flush_nxt;
      ack_r     <= req;
      dat_r     <= rd ? rdata : `ZERO_WORD;
      irq_r     <= irq_nxt;
      ws_in_q   <= word_select_i;
      lrst_r    <= lrst;
    end
  end

  assign dat_o                = dat_r;
  assign ack_o                = ack_r;
  assign irq_o                = irq_r;
  assign word_select_o        = wso_r;
  assign word_select_oe_o     = wsoe_r;
  assign list_pointer_reset_o = lrst_r;
  assign port_active_o        = act_r;
  assign dma_flush_o          = flush_r;
endmodule

/* test/audio_slot_monitor.sv */
// Port-level checks of the audio slot control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module audio_slot_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        irq_o,
  input wire logic [4:0]  word_select_oe_o,
  input wire logic [1:0]  slot_pointer_reset_i,
  input wire logic [1:0]  list_pointer_reset_o,
  input wire logic [1:0]  port_active_o,
  input wire logic [1:0]  bit_tick_o,
  input wire logic [3:0]  dma_flush_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  logic       seen;
  // Saturates so a port start long after any pointer reset is caught
  assign seen = (slot_pointer_reset_i != 2'h0) ||
                (list_pointer_reset_o != 2'h0);
  assign since_nxt = seen ? 4'h0 :
                     (since_r == 4'hf) ? since_r : since_r + 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_r <= 4'hf;
    end else begin
      since_r <= since_nxt;
    end
  end
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  sequence s_start;
    (port_active_o & ~$past(port_active_o)) != 2'h0;
  endsequence
  ack_follow_a: assert property (s_req |=> s_ack)
    else $error("ack late or longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  tick_one_a: assert property (bit_tick_o[0] |=> !bit_tick_o[0])
    else $error("port one bit tick too long");
  tick_two_a: assert property (bit_tick_o[1] |=> !bit_tick_o[1])
    else $error("port two bit tick too long");
  flush_pulse_a: assert property (dma_flush_o != 4'h0
    |=> dma_flush_o == 4'h0)
    else $error("flush pulse too long");
  port_start_a: assert property (s_start |-> since_nxt < 4'h6)
    else $error("port started without pointer reset");
  quiet_start_a: assert property ($fell(rst_i) |-> !irq_o
    && !ack_o && port_active_o == 2'h0 && word_select_oe_o == 5'h00)
    else $error("outputs active after reset");
endmodule

bind audio_slot_serial_control audio_slot_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
  .word_select_oe_o(word_select_oe_o),
  .slot_pointer_reset_i(slot_pointer_reset_i),
  .list_pointer_reset_o(list_pointer_reset_o),
  .port_active_o(port_active_o), .bit_tick_o(bit_tick_o),
  .dma_flush_o(dma_flush_o)
);

/* test/audio_codec_model.sv */
// Behavioural codec: free-running bit clocks, master clock, frame sync.
// Assumes the codec is clock master, so its clocks never stop.
`timescale 1ns/1ps
module audio_codec_model (
  input  wire logic sync_en_i,
  output logic      bit_clock_one_o,
  output logic      bit_clock_two_o,
  output logic      master_clock_o,
  output logic [4:0] ws_o
);
  logic [4:0] cnt = 5'h00;
  initial begin
    bit_clock_one_o = 1'b0;
    bit_clock_two_o = 1'b0;
    master_clock_o = 1'b0;
  end
  always #30 bit_clock_one_o = ~bit_clock_one_o;
  always #50 bit_clock_two_o = ~bit_clock_two_o;
  always #20 master_clock_o = ~master_clock_o;
  always @(posedge bit_clock_one_o) cnt <= cnt + 5'h01;
  // Lines have no pull: without sync they wander with the bit clock
  assign ws_o = sync_en_i ? {5{cnt[4]}} : {5{cnt[0]}};
endmodule

/* test/audio_slot_serial_control_tb_top.sv */
// Self-checking bench of the audio slot control block.
// Assumes the codec model and a small slot engine made here.
`timescale 1ns/1ps
`include "audio_slot_defines.svh"
module audio_slot_serial_control_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [1:0]  next_msb = 2'h0;
  logic [1:0]  sf_next = 2'h0;
  logic [1:0]  ptr_rst = 2'h0;
  logic [4:0]  mark_one = 5'h00;
  logic        prot = 1'b0;
  logic        s_val = 1'b0;
  logic [4:0]  s_rec = 5'h00;
  logic [7:0]  s_byte = 8'h00;
  logic        sync_en = 1'b0;
  logic [2:0]  bitn = 3'h0;
  logic        slotn = 1'b0;
  logic [31:0] rd;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire         irq_o;
  wire         pin1;
  wire         pin2;
  wire         mclk;
  wire  [4:0]  ws_o;
  wire  [4:0]  ws_oe;
  wire  [4:0]  ws_m;
  wire  [1:0]  lst_rst;
  wire  [1:0]  active;
  wire  [1:0]  tick;
  wire  [3:0]  flush;
  int          n_errors = 0;
  int          n_checks = 0;
  int          g;
  int          k;
  int          i;
  int          dv[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128,
                          192, 256, 384};
  int          tw[4] = '{8, 8, 1, 2};
  logic [31:0] base = 32'h200c_c04c;

  always #5 clk_i = ~clk_i;

  audio_slot_serial_control dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o),
    .bit_clock_pin_one_i(pin1), .bit_clock_pin_two_i(pin2),
    .audio_master_clock_i(mclk),
    .word_select_i((ws_oe & ws_o) | (~ws_oe & ws_m)),
    .word_select_o(ws_o), .word_select_oe_o(ws_oe),
    .slot_next_msb_i(next_msb), .superframe_next_i(sf_next),
    .ws_mark_one_i(mark_one), .ws_mark_two_i(5'h00),
    .slot_pointer_reset_i(ptr_rst), .protection_reached_i(prot),
    .sample_valid_i(s_val), .sample_record_i(s_rec),
    .sample_msb_byte_i(s_byte), .list_pointer_reset_o(lst_rst),
    .port_active_o(active), .bit_tick_o(tick), .dma_flush_o(flush)
  );
  audio_codec_model codec (
    .sync_en_i(sync_en), .bit_clock_one_o(pin1), .bit_clock_two_o(pin2),
    .master_clock_o(mclk), .ws_o(ws_m)
  );

  // Slot engine: 8-bit slots, every other slot marked on line 3
  always @(posedge clk_i) begin
    if (tick[0] === 1'b1) begin
      bitn <= bitn + 3'h1;
      next_msb[0] <= (bitn == 3'h6);
      mark_one <= {1'b0, ~slotn, 3'h0};
      sf_next[0] <= ~slotn;
      if (bitn == 3'h7) slotn <= ~slotn;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic smp(input logic [4:0] r, input logic [7:0] b);
    @(posedge clk_i);
    s_val <= 1'b1;
    s_rec <= r;
    s_byte <= b;
    @(posedge clk_i);
    s_val <= 1'b0;
  endtask

  task automatic pulse(input int w);
    @(posedge clk_i);
    if (w < 2) ptr_rst[w] <= 1'b1;
    else prot <= 1'b1;
    @(posedge clk_i);
    ptr_rst <= 2'h0;
    prot <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Cycles between two bit ticks of one port
  task automatic gap(input int p);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick[p] !== 1'b1 && n < 5000);
    g = 0;
    do begin
      @(posedge clk_i);
      g++;
    end while (tick[p] !== 1'b1 && g < 5000);
  endtask

  // Width of the next word-select pulse on line 3, in bit ticks
  task automatic wid();
    int n;
    n = 0;
    k = 0;
    while (ws_o[3] !== 1'b0 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    while (ws_o[3] !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    while (ws_o[3] === 1'b1 && n < 600) begin
      if (tick[0] === 1'b1) k++;
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(`OFF_AUDIO_CFG, `CFG_RESET);
    rdchk(`OFF_CLK_CFG, `CFG_RESET);
    rdchk(`OFF_LEVEL, `ZERO_WORD);
    rdchk(`OFF_DMA_EN, `CFG_RESET);
    wb(1'b1, 12'h100, 32'hffff_ffff);
    rdchk(12'h100, `ZERO_WORD);
    wb(1'b1, `OFF_AUDIO_CFG, 32'h1000_0000);
    smp(5'd3, 8'h41);
    smp(5'd5, 8'hc0);
    smp(5'd20, 8'hbf);
    smp(5'd7, 8'h80);
    smp(5'd9, 8'h40);
    rdchk(`OFF_LEVEL, 32'h0010_0088);
    rdchk(`OFF_LEVEL, `ZERO_WORD);
    wb(1'b1, `OFF_AUDIO_CFG, 32'h1fc0_0000);
    smp(5'd31, 8'h7f);
    smp(5'd16, 8'h81);
    smp(5'd30, 8'h80);
    rdchk(`OFF_LEVEL, 32'h4000_0000);
    wb(1'b1, `OFF_IRQ_MASK, `ONE_WORD);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b0, `OFF_IRQ_STAT, `ZERO_WORD);
    chk(rd & `ONE_WORD, `ONE_WORD);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    for (i = 0; i < 19; i++) begin
      wb(1'b1, `OFF_CLK_CFG, 32'(i) << 27);
      gap(0);
      gap(0);
      chk(g, (i == 0) ? 6 : (i == 1) ? 10 :
             (i == 2) ? 4 : dv[i-3] * 4);
    end
    wb(1'b1, `OFF_CLK_CFG, 32'h9800_0000);
    repeat (4) @(posedge clk_i);
    k = 0;
    repeat (400) begin
      @(posedge clk_i);
      if (tick[0] === 1'b1) k++;
    end
    chk(k, 0);
    wb(1'b1, `OFF_CLK_CFG, 32'h0000_0000);
    gap(1);
    gap(1);
    chk(g, 10);
    wb(1'b1, `OFF_CLK_CFG, 32'h0040_0000);
    gap(1);
    gap(1);
    chk(g, 6);
    wb(1'b1, `OFF_DMA_EN, 32'h0000_000f);
    wb(1'b1, `OFF_AUDIO_CFG, base);
    repeat (20) @(posedge clk_i);
    chk({ws_oe[2:1], ws_o[1]}, 3'b010);
    chk(active, 2'b00);
    pulse(0);
    chk(active, 2'b01);
    wb(1'b1, `OFF_CLK_CFG, 32'h1000_0000);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, `OFF_AUDIO_CFG, base | (32'(i) << 4));
      pulse(2);
      wid();
      wid();
      chk(k, tw[i]);
    end
    wb(1'b1, `OFF_AUDIO_CFG, base | 32'h6000_0000);
    pulse(1);
    chk(active, 2'b01);
    pulse(2);
    pulse(1);
    chk(active, 2'b11);
    wb(1'b1, `OFF_AUDIO_CFG, 32'h0000_c00c);
    repeat (4) @(posedge clk_i);
    chk(active, 2'b11);
    pulse(2);
    chk(active, 2'b00);
    sync_en <= 1'b1;
    k = 0;
    repeat (600) begin
      @(posedge clk_i);
      if (lst_rst[0] === 1'b1) k++;
    end
    chk(k > 1, 1'b1);
    chk(ws_oe[0], 1'b0);
    wb(1'b1, `OFF_DMA_EN, 32'h0000_0005);
    g = flush;
    repeat (4) begin
      @(posedge clk_i);
      g = g | flush;
    end
    chk(g, 32'h0000_000a);
    test_done();
  end
endmodule
